// >>> core/mae_exec_core.sv
// apb-reached execution unit for the single-operand instruction subset
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "mae_defs.svh"

// Notes on behaviour
// - complement memory into working register, zero flag
// - low nibble over nine or flag: add six
// - high nibble over nine or carry: add six
// - add 00/06/60/66, result into memory
// - adjust touches only byte overflow flag
// - minus one written back to memory
// - minus one into working register only
// - power-down halts, stops clock, keeps contents
// - power-down clears watchdog count and prescaler
// - power-down sets sleep, clears watchdog expiry
// - plus one written back to memory
module mae_exec_core
	import mae_pkg::*;
#(
	parameter int MEM_WORDS = 16,
	parameter int ADDR_W = 4
)
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from outside the clock domain
	input wire logic wdog_timeout,
	input wire logic wake_req,
	// system control
	output logic sysclk_en,
	output logic wdt_count_clr,
	output logic wdt_prescale_clr
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		mae_state_e state;
		mae_op_e op;
		logic [ADDR_W-1:0] addr;
		mae_byte_t work;
		logic zero;
		logic byte_ovf;
		logic nib_ovf;
		logic sleep;
		logic wdx;
		logic [MEM_WORDS-1:0][7:0] mem;
		logic [31:0] rdata;
		logic slverr;
		logic clr_pulse;
		logic [1:0] tmo_sync;
		logic [1:0] wake_sync;
		logic tmo_last;
	} mae_core_s;

	mae_core_s st_reg;
	mae_core_s st_next;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic is_mem(input logic [11:0] a);
		return (a >= `MAE_OFS_MEM_LO) && (a <= `MAE_OFS_MEM_HI) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [ADDR_W-1:0] mem_index(input logic [11:0] a);
		logic [11:0] off;
		off = a - `MAE_OFS_MEM_LO;
		return off[ADDR_W+1:2];
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		return is_reg(a, `MAE_OFS_CMD) || is_reg(a, `MAE_OFS_WORK) ||
			is_reg(a, `MAE_OFS_FLAGS) || is_mem(a);
	endfunction

	// bytes read back zero-extended into the bus word
	function automatic logic [31:0] byte_word(input mae_byte_t b);
		return {24'h000000, b};
	endfunction

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	mae_byte_t opnd;
	mae_step_e step_kind;
	mae_byte_t step_res;
	logic step_zero;
	mae_byte_t bcd_sum;
	logic bcd_ovf;

	assign opnd = st_reg.mem[st_reg.addr];

	always_comb begin
		case (st_reg.op)
			OP_COMPL_WORK: step_kind = STEP_COMPL;
			OP_MINUS_MEM: step_kind = STEP_MINUS;
			OP_MINUS_WORK: step_kind = STEP_MINUS;
			default: step_kind = STEP_PLUS;
		endcase
	end

	mae_step_unit u_step (
		.opnd(opnd),
		.kind(step_kind),
		.res(step_res),
		.zero(step_zero)
	);

	mae_bcd_adjust u_bcd (
		.work(st_reg.work),
		.byte_ovf_in(st_reg.byte_ovf),
		.nib_ovf_in(st_reg.nib_ovf),
		.sum(bcd_sum),
		.byte_ovf_out(bcd_ovf)
	);

	// ----------------------------------------
	// state decode
	// ----------------------------------------
	logic idle;
	logic busy;
	logic halted;

	assign idle = (st_reg.state == ST_IDLE);
	assign busy = (st_reg.state == ST_EXEC);
	assign halted = (st_reg.state == ST_HALT);

	// ----------------------------------------
	// bus signals
	// ----------------------------------------
	logic setup;
	logic wr_take;
	logic tmo_rise;
	logic [31:0] flag_word;
	logic [31:0] cmd_word;

	assign setup = psel && !penable;
	assign wr_take = psel && penable && pwrite && pready;
	// single wait-free access phase: read data is staged during setup
	assign pready = 1'b1;
	assign prdata = st_reg.rdata;
	assign pslverr = st_reg.slverr;

	// stopped system clock while halted; registers keep their contents
	assign sysclk_en = !halted;
	assign wdt_count_clr = st_reg.clr_pulse;
	assign wdt_prescale_clr = st_reg.clr_pulse;

	// only the second sync stage feeds the edge detector
	assign tmo_rise = st_reg.tmo_sync[1] && !st_reg.tmo_last;

	always_comb begin
		flag_word = `MAE_WORD_ZERO;
		flag_word[`MAE_FLG_ZERO] = st_reg.zero;
		flag_word[`MAE_FLG_BYTE_OVF] = st_reg.byte_ovf;
		flag_word[`MAE_FLG_NIB_OVF] = st_reg.nib_ovf;
		flag_word[`MAE_FLG_SLEEP] = st_reg.sleep;
		flag_word[`MAE_FLG_WDX] = st_reg.wdx;
	end

	always_comb begin
		cmd_word = `MAE_WORD_ZERO;
		cmd_word[`MAE_CMD_OP_MSB:`MAE_CMD_OP_LSB] = st_reg.op;
		cmd_word[`MAE_CMD_ADDR_LSB+ADDR_W-1:`MAE_CMD_ADDR_LSB] = st_reg.addr;
		cmd_word[`MAE_CMD_BUSY] = busy;
		cmd_word[`MAE_CMD_HALTED] = halted;
	end

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	logic wr_cmd;
	logic wr_work;
	logic wr_flags;
	logic wr_mem;
	logic wr_go;
	logic wr_wake;

	// refusing go while busy or halted keeps a running instruction's operands intact
	assign wr_cmd = wr_take && is_reg(paddr, `MAE_OFS_CMD);
	assign wr_work = wr_take && is_reg(paddr, `MAE_OFS_WORK);
	assign wr_flags = wr_take && is_reg(paddr, `MAE_OFS_FLAGS);
	assign wr_mem = wr_take && is_mem(paddr);
	assign wr_go = wr_cmd && idle && pwdata[`MAE_CMD_GO];
	assign wr_wake = wr_cmd && halted && pwdata[`MAE_CMD_WAKE];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.clr_pulse = 1'b0;
		st_next.tmo_sync = {st_reg.tmo_sync[0], wdog_timeout};
		st_next.wake_sync = {st_reg.wake_sync[0], wake_req};
		st_next.tmo_last = st_reg.tmo_sync[1];

		// ----------------------------------------
		// read staging during setup
		// ----------------------------------------
		if (setup) begin
			st_next.slverr = !is_mapped(paddr);
			if (pwrite) begin
				st_next.rdata = `MAE_WORD_ZERO;
			end else if (is_reg(paddr, `MAE_OFS_CMD)) begin
				st_next.rdata = cmd_word;
			end else if (is_reg(paddr, `MAE_OFS_WORK)) begin
				st_next.rdata = byte_word(st_reg.work);
			end else if (is_reg(paddr, `MAE_OFS_FLAGS)) begin
				st_next.rdata = flag_word;
			end else if (is_mem(paddr)) begin
				st_next.rdata = byte_word(st_reg.mem[mem_index(paddr)]);
			end else begin
				st_next.rdata = `MAE_WORD_ZERO;
			end
		end

		// ----------------------------------------
		// software writes
		// ----------------------------------------
		if (wr_go) begin
			st_next.op = mae_op_e'(pwdata[`MAE_CMD_OP_MSB:`MAE_CMD_OP_LSB]);
			st_next.addr = pwdata[`MAE_CMD_ADDR_LSB+ADDR_W-1:`MAE_CMD_ADDR_LSB];
			st_next.state = ST_EXEC;
		end else if (wr_wake) begin
			st_next.state = ST_IDLE;
		end
		if (wr_work && idle) begin
			st_next.work = pwdata[7:0];
		end
		if (wr_flags) begin
			if (idle) begin
				st_next.zero = pwdata[`MAE_FLG_ZERO];
				st_next.byte_ovf = pwdata[`MAE_FLG_BYTE_OVF];
				st_next.nib_ovf = pwdata[`MAE_FLG_NIB_OVF];
			end
			// sleep and expiry stay writable so software can clear them after wake
			st_next.sleep = pwdata[`MAE_FLG_SLEEP];
			st_next.wdx = pwdata[`MAE_FLG_WDX];
		end
		if (wr_mem && idle) begin
			st_next.mem[mem_index(paddr)] = pwdata[7:0];
		end

		// ----------------------------------------
		// instruction sequencing
		// ----------------------------------------
		case (st_reg.state)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				st_next.state = ST_IDLE;
				case (st_reg.op)
					OP_COMPL_WORK: begin
						st_next.work = step_res;
						st_next.zero = step_zero;
					end
					OP_BCD_ADJUST: begin
						st_next.mem[st_reg.addr] = bcd_sum;
						st_next.byte_ovf = bcd_ovf;
					end
					OP_MINUS_MEM: begin
						st_next.mem[st_reg.addr] = step_res;
						st_next.zero = step_zero;
					end
					OP_MINUS_WORK: begin
						st_next.work = step_res;
						st_next.zero = step_zero;
					end
					OP_PLUS_MEM: begin
						st_next.mem[st_reg.addr] = step_res;
						st_next.zero = step_zero;
					end
					OP_PLUS_WORK: begin
						st_next.work = step_res;
						st_next.zero = step_zero;
					end
					OP_SLEEP: begin
						st_next.state = ST_HALT;
						st_next.clr_pulse = 1'b1;
						st_next.sleep = 1'b1;
						st_next.wdx = 1'b0;
					end
					default: begin
					end
				endcase
			end
			ST_HALT: begin
				// the wake pin leaves halt here, the wake command through the write decode
				if (st_reg.wake_sync[1]) begin
					st_next.state = ST_IDLE;
				end
			end
			default: begin
				st_next.state = ST_IDLE;
			end
		endcase

		// a timeout edge beats any clear in the same cycle
		if (tmo_rise) begin
			st_next.wdx = 1'b1;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.state <= ST_IDLE;
			st_reg.op <= OP_NONE;
			st_reg.addr <= '0;
			st_reg.work <= `MAE_BYTE_ZERO;
			st_reg.zero <= 1'b0;
			st_reg.byte_ovf <= 1'b0;
			st_reg.nib_ovf <= 1'b0;
			st_reg.sleep <= 1'b0;
			st_reg.wdx <= 1'b0;
			st_reg.mem <= '0;
			st_reg.rdata <= `MAE_WORD_ZERO;
			st_reg.slverr <= 1'b0;
			st_reg.clr_pulse <= 1'b0;
			st_reg.tmo_sync <= 2'h0;
			st_reg.wake_sync <= 2'h0;
			st_reg.tmo_last <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

// >>> inc/mae_defs.svh
// register offsets, field positions and arithmetic constants of the alu subset block
`ifndef MAE_DEFS_SVH
`define MAE_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MAE_OFS_CMD 12'h000
`define MAE_OFS_WORK 12'h004
`define MAE_OFS_FLAGS 12'h008
`define MAE_OFS_MEM_LO 12'h040
`define MAE_OFS_MEM_HI 12'h07C

// ----------------------------------------
// command register fields
// ----------------------------------------
`define MAE_CMD_OP_LSB 0
`define MAE_CMD_OP_MSB 2
`define MAE_CMD_ADDR_LSB 4
`define MAE_CMD_ADDR_MSB 7
`define MAE_CMD_GO 8
`define MAE_CMD_WAKE 9
`define MAE_CMD_BUSY 16
`define MAE_CMD_HALTED 17

// ----------------------------------------
// flag register fields
// ----------------------------------------
`define MAE_FLG_ZERO 0
`define MAE_FLG_BYTE_OVF 1
`define MAE_FLG_NIB_OVF 2
`define MAE_FLG_SLEEP 3
`define MAE_FLG_WDX 4

// ----------------------------------------
// arithmetic constants
// ----------------------------------------
`define MAE_NIB_MAX 4'h9
`define MAE_ADJ_NONE 8'h00
`define MAE_ADJ_LO 8'h06
`define MAE_ADJ_HI 8'h60
`define MAE_ADJ_BOTH 8'h66
`define MAE_ONE 8'h01
`define MAE_BYTE_ZERO 8'h00
`define MAE_WORD_ZERO 32'h00000000

`endif

// >>> inc/mae_pkg.sv
// types shared by the alu subset block
package mae_pkg;

	// operation codes as written into the command register
	typedef enum logic [2:0] {
		OP_NONE,
		OP_COMPL_WORK,
		OP_BCD_ADJUST,
		OP_MINUS_MEM,
		OP_MINUS_WORK,
		OP_PLUS_MEM,
		OP_PLUS_WORK,
		OP_SLEEP
	} mae_op_e;

	// step unit operand treatment
	typedef enum logic [1:0] {
		STEP_COMPL,
		STEP_MINUS,
		STEP_PLUS
	} mae_step_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_HALT
	} mae_state_e;

	typedef logic [7:0] mae_byte_t;

endpackage

// >>> core/mae_bcd_adjust.sv
// decimal correction of the working register after a bcd addition
`timescale 1ns/100ps
module mae_bcd_adjust
	import mae_pkg::*;
(
	// operand and flags
	input wire mae_byte_t work,
	input wire logic byte_ovf_in,
	input wire logic nib_ovf_in,
	// result
	output mae_byte_t sum,
	output logic byte_ovf_out
);
	logic lo_fix;
	logic hi_fix;
	logic [8:0] wide;
	logic [7:0] addend;

	always_comb begin
		lo_fix = (work[3:0] > `MAE_NIB_MAX) || nib_ovf_in;
		hi_fix = (work[7:4] > `MAE_NIB_MAX) || byte_ovf_in;
		if (lo_fix && hi_fix) begin
			addend = `MAE_ADJ_BOTH;
		end else if (hi_fix) begin
			addend = `MAE_ADJ_HI;
		end else if (lo_fix) begin
			addend = `MAE_ADJ_LO;
		end else begin
			addend = `MAE_ADJ_NONE;
		end
		wide = {1'b0, work} + {1'b0, addend};
		sum = wide[7:0];
		// a carry already set stays set so multi-byte sums chain
		byte_ovf_out = byte_ovf_in || wide[8];
	end
endmodule

// >>> core/mae_step_unit.sv
// complement, minus one and plus one on a memory operand, with zero detect
`timescale 1ns/100ps
module mae_step_unit
	import mae_pkg::*;
(
	// operand
	input wire mae_byte_t opnd,
	input wire mae_step_e kind,
	// result
	output mae_byte_t res,
	output logic zero
);
	always_comb begin
		case (kind)
			STEP_COMPL: res = ~opnd;
			STEP_MINUS: res = opnd - `MAE_ONE;
			STEP_PLUS: res = opnd + `MAE_ONE;
			default: res = opnd;
		endcase
		zero = (res == `MAE_BYTE_ZERO);
	end
endmodule

// >>> bench/mae_exec_core_checker.sv
// assertion checker for the alu subset execution unit
`timescale 1ns/100ps
module mae_exec_core_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// system pins
	input wire logic wdog_timeout,
	input wire logic wake_req,
	input wire logic sysclk_en,
	input wire logic wdt_count_clr,
	input wire logic wdt_prescale_clr
);
	logic acc;
	logic halt_go;
	logic mapped;
	assign acc = psel && penable;
	assign halt_go = acc && pwrite && paddr == 12'h000 && pwdata[8] && pwdata[2:0] == 3'h7;
	assign mapped = paddr[1:0] == 2'h0 && (paddr < 12'h00C || (paddr >= 12'h040 && paddr <= 12'h07C));
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_clr_pair: assert property (wdt_count_clr == wdt_prescale_clr)
		else $error("watchdog clears differ");
	chk_halt_go: assert property (halt_go && sysclk_en |-> ##2 (!sysclk_en && wdt_count_clr))
		else $error("power-down did not halt");
	chk_clr_once: assert property (wdt_count_clr |=> !wdt_count_clr)
		else $error("clear pulse too long");
	chk_idle_clr: assert property (sysclk_en |-> !wdt_count_clr)
		else $error("clear without halt");
	chk_wake_exit: assert property ((!sysclk_en && wake_req) ##1 wake_req [*3] |-> sysclk_en)
		else $error("wake did not resume");
	chk_ready_high: assert property (acc |-> pready)
		else $error("pready low");
	chk_slverr_map: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr wrong");
	chk_err_data: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

bind mae_exec_core mae_exec_core_checker mae_exec_core_checker_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wdog_timeout, .wake_req, .sysclk_en,
	.wdt_count_clr, .wdt_prescale_clr);

// >>> bench/mae_exec_core_bench.sv
// self-checking bench for the alu subset execution unit
`timescale 1ns/100ps
`include "mae_defs.svh"
module mae_exec_core_bench;
	typedef struct packed {logic [2:0] op; logic [7:0] m, w, f, xw, xm, xf;} mae_row_s;
	// op, memory, work, flags in; work, memory, flags expected
	mae_row_s rows [16] = '{
		'{3'h1, 8'hA5, 8'h00, 8'h00, 8'h5A, 8'hA5, 8'h00},
		'{3'h1, 8'hFF, 8'h33, 8'h00, 8'h00, 8'hFF, 8'h01},
		'{3'h2, 8'h00, 8'h7B, 8'h01, 8'h7B, 8'h81, 8'h01},
		'{3'h2, 8'h00, 8'h12, 8'h04, 8'h12, 8'h18, 8'h04},
		'{3'h2, 8'h00, 8'hA3, 8'h00, 8'hA3, 8'h03, 8'h02},
		'{3'h2, 8'h00, 8'h25, 8'h02, 8'h25, 8'h85, 8'h02},
		'{3'h2, 8'h00, 8'h9A, 8'h00, 8'h9A, 8'hA0, 8'h00},
		'{3'h2, 8'h00, 8'h99, 8'h00, 8'h99, 8'h99, 8'h00},
		'{3'h3, 8'h01, 8'h33, 8'h00, 8'h33, 8'h00, 8'h01},
		'{3'h3, 8'h00, 8'h33, 8'h01, 8'h33, 8'hFF, 8'h00},
		'{3'h4, 8'h01, 8'h33, 8'h00, 8'h00, 8'h01, 8'h01},
		'{3'h4, 8'h10, 8'h33, 8'h01, 8'h0F, 8'h10, 8'h00},
		'{3'h5, 8'hFF, 8'h33, 8'h00, 8'h33, 8'h00, 8'h01},
		'{3'h5, 8'h7F, 8'h33, 8'h01, 8'h33, 8'h80, 8'h00},
		'{3'h6, 8'h41, 8'h00, 8'h01, 8'h42, 8'h41, 8'h00},
		'{3'h0, 8'h5C, 8'h42, 8'h07, 8'h42, 8'h5C, 8'h07}
	};
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic wdog_timeout = 1'h0;
	logic wake_req = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready, pslverr, sysclk_en, wdt_count_clr, wdt_prescale_clr, e;
	int mismatches = 0;
	int cmp_count = 0;
	int clr_seen = 0;

	mae_exec_core mae_exec_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .wdog_timeout, .wake_req, .sysclk_en, .wdt_count_clr,
		.wdt_prescale_clr);

	initial forever #12.5 pclk = ~pclk;

	// the clear pulse lasts one cycle, so each power-down adds exactly one
	always @(posedge pclk)
		if (wdt_count_clr === 1'h1 && wdt_prescale_clr === 1'h1)
			clr_seen <= clr_seen + 1;

	task automatic end_sim;
		if (mismatches == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// -----------------------------
	// apb master, waits on pready
	// -----------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			mismatches++;
			end_sim();
		end
	endtask

	function automatic logic [11:0] ma(input int i);
		return `MAE_OFS_MEM_LO + 12'(4 * i);
	endfunction

	initial begin
		int n;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i]) begin
			apb(1'h1, ma(i), 32'(rows[i].m));
			apb(1'h1, `MAE_OFS_WORK, 32'(rows[i].w));
			apb(1'h1, `MAE_OFS_FLAGS, 32'(rows[i].f));
			apb(1'h1, `MAE_OFS_CMD, {23'h0, 1'h1, i[3:0], 1'h0, rows[i].op});
			apb(1'h0, `MAE_OFS_WORK, 32'h0);
			chk("work", q, 32'(rows[i].xw));
			apb(1'h0, ma(i), 32'h0);
			chk("mem", q, 32'(rows[i].xm));
			apb(1'h0, `MAE_OFS_FLAGS, 32'h0);
			chk("flags", q, 32'(rows[i].xf));
		end
		// unmapped, unaligned and reserved places
		apb(1'h0, 12'h010, 32'h0);
		chk("err", 32'(e), 32'h1);
		apb(1'h1, 12'h041, 32'hFFFFFFFF);
		chk("err", 32'(e), 32'h1);
		apb(1'h0, ma(0), 32'h0);
		chk("err mem", q, 32'hA5);
		// expiry raised by the pin, then power-down
		wdog_timeout <= 1'h1;
		repeat (4) @(posedge pclk);
		apb(1'h0, `MAE_OFS_FLAGS, 32'h0);
		chk("expiry", q, 32'h17);
		// pin back to its idle level so a later reset sees no edge
		wdog_timeout <= 1'h0;
		apb(1'h1, `MAE_OFS_FLAGS, 32'h15);
		apb(1'h1, `MAE_OFS_CMD, 32'h107);
		apb(1'h0, `MAE_OFS_FLAGS, 32'h0);
		chk("halt flags", q, 32'h0D);
		chk("clock", 32'(sysclk_en), 32'h0);
		chk("clears", 32'(clr_seen), 32'h1);
		apb(1'h1, `MAE_OFS_WORK, 32'hEE);
		apb(1'h0, `MAE_OFS_WORK, 32'h0);
		chk("halt work", q, 32'h42);
		apb(1'h0, ma(13), 32'h0);
		chk("halt mem", q, 32'h80);
		apb(1'h0, `MAE_OFS_CMD, 32'h0);
		chk("halt cmd", q, 32'h00020007);
		wake_req <= 1'h1;
		for (n = 0; n < 10 && sysclk_en !== 1'h1; n++)
			@(posedge pclk);
		chk("wake", 32'(sysclk_en), 32'h1);
		wake_req <= 1'h0;
		// second power-down, left by the wake command instead of the pin
		apb(1'h1, `MAE_OFS_CMD, 32'h107);
		apb(1'h0, `MAE_OFS_CMD, 32'h0);
		chk("halt cmd2", q, 32'h00020007);
		apb(1'h1, `MAE_OFS_CMD, 32'h200);
		apb(1'h0, `MAE_OFS_CMD, 32'h0);
		chk("wake cmd", q, 32'h00000007);
		chk("clears2", 32'(clr_seen), 32'h2);
		// second reset in mid-run
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `MAE_OFS_WORK, 32'h0);
		chk("rst work", q, 32'h0);
		apb(1'h0, ma(13), 32'h0);
		chk("rst mem", q, 32'h0);
		apb(1'h0, `MAE_OFS_FLAGS, 32'h0);
		chk("rst flags", q, 32'h0);
		end_sim();
	end
endmodule
